// >>> dcr_defs.svh
// offsets, field positions, reset values and timing figures for the
// driver configuration and status register bank; definitions only
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH

// ==========================================================
// register addresses (7-bit, serial datagram address byte)
`define DCR_ADDR_CHOPPER_CONFIG 7'h6c
`define DCR_ADDR_CURRENT_CONTROL_CONFIG 7'h6d
`define DCR_ADDR_COMMUTATION_CONTROL 7'h6e
`define DCR_ADDR_DRIVER_STATUS 7'h6f
`define DCR_ADDR_VOLTAGE_PWM_CONFIG 7'h70
`define DCR_ADDR_PWM_AMPLITUDE_RESULT 7'h71
`define DCR_ADDR_PWM_AUTO_RESULT 7'h72

// ==========================================================
// reset values
`define DCR_RST_CHOPPER_CONFIG 32'h10410150
`define DCR_RST_VOLTAGE_PWM_CONFIG 22'h0c001e
`define DCR_RST_VOLTAGE_PWM_CONFIG_FULL 32'hc40c001e
`define DCR_RST_ZERO 32'h00000000

// ==========================================================
// field positions
`define DCR_TIME_LIMIT_MSB 9
`define DCR_TIME_LIMIT_LSB 0
`define DCR_STALL_LIMIT_MSB 23
`define DCR_STALL_LIMIT_LSB 16
`define DCR_WRITE_BIT 39
`define DCR_ADDR_MSB 38
`define DCR_ADDR_LSB 32

// ==========================================================
// register widths
`define DCR_W_CURRENT_CONTROL 25
`define DCR_W_COMMUTATION 24
`define DCR_W_VOLTAGE_PWM 22

// ==========================================================
// timing
`define DCR_CLK_PERIOD_NS 4
`define DCR_TIME_LIMIT_UNIT_CYC 1
`define DCR_STALL_LIMIT_UNIT_CYC 16
`define DCR_DATAGRAM_BITS 40

`endif

// >>> dcr_pkg.sv
// types shared by the driver configuration and status register bank
// assumes dcr_defs.svh is on the include path
package dcr_pkg;
	// ==========================================================
	// regulator results presented by the voltage-pwm core
	typedef struct packed {
		logic [8:0] scale_auto; // signed offset, -255..+255
		logic [7:0] actual_duty_cycle; // 255 = full voltage
	} dcr_amp_t;

	typedef struct packed {
		logic [7:0] gradient_auto;
		logic [7:0] offset_auto;
	} dcr_auto_t;

	// commutation limits handed to the commutation core
	typedef struct packed {
		logic [7:0] commutation_stall_limit;
		logic [9:0] commutation_time_limit;
	} dcr_limits_t;
endpackage

// >>> dcr_driver_config_status_regs.sv
// driver configuration/status register bank behind the serial port
// assumes 40-bit mode-3 datagrams from an external host; core inputs
// are on clk_sys, serial pins and the enable pin are asynchronous and synchronised here
//
// Summary of operation
// RULE1: the on-time of a commutation pwm pulse is cut once it reaches the time-limit field in device clocks.
// RULE2: the step-loss field gives the longest on-time for step-loss detection in units of sixteen clocks.
// RULE3: a step-loss field of zero turns step-loss detection off.
// RULE4: automatic commutation runs when the enable pin is high or the minimum commutation velocity is nonzero.
// RULE5: step-loss detection also works above the high-velocity threshold when high-velocity fullstep is on.
// RULE6: the low byte of the amplitude result shows the actual duty cycle that scales both phase currents.
// RULE7: bits 24 to 16 of the amplitude result show the signed regulator offset added to the duty cycle.
// RULE8: the low byte of the automatic result shows the automatically found offset, read only.
// RULE9: the chopper configuration is read/write and resets to 0x10410150.
// RULE10: the voltage-pwm configuration is write only and resets to 0xC40C001E; the code keeps only bits 21:0, which reset to 0x0C001E.
// RULE11: the driver status register shows the load value and the driver error flags.
// RULE12: write-only registers hold the last written value until the next write or a reset.
`timescale 1ns/1ns
`include "dcr_defs.svh"

module dcr_driver_config_status_regs (
	input wire logic clk_sys, // device clock, 250 MHz
	input wire logic rst_b, // synchronous reset, active low
	input wire logic spi_sck, // serial clock pin, idles high
	input wire logic spi_cs_b, // chip select pin, active low
	input wire logic spi_sdi, // serial data in
	output logic spi_sdo, // serial data out
	output logic spi_sdo_oe, // high while sdo is driven
	input wire logic [7:0] spi_status, // status byte sent first
	input wire logic commutation_enable_pin, // asynchronous pin
	input wire logic [22:0] min_commutation_velocity, // same clock
	input wire logic high_velocity_fullstep_en, // same clock
	input wire logic above_high_velocity_threshold, // same clock
	input wire logic pwm_on, // pwm on-phase active, same clock
	input wire logic [31:0] driver_status_in, // load and error flags
	input wire dcr_pkg::dcr_amp_t amp_in, // regulator results
	input wire dcr_pkg::dcr_auto_t auto_in, // automatic results
	output logic [31:0] chopper_config, // chopper configuration
	output logic [24:0] current_control_config, // current control
	output logic [21:0] voltage_pwm_config, // voltage pwm config
	output dcr_pkg::dcr_limits_t limits, // commutation limits
	output logic auto_commutation_active, // commutation mode on
	output logic stall_detect_active, // step-loss check armed
	output logic commutation_cut, // on-time limit reached
	output logic step_loss // on-time beyond step-loss limit
);
	import dcr_pkg::*;

	// ==========================================================
	// pin synchronisers; stage 1 feeds stage 2 only
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic sck_d_r;
	logic cs_b_d_r;
	logic sck_s;
	logic cs_b_s;
	logic sdi_s;
	logic en_pin_s;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			// enable pin idles low; a high reset here would fake a mode entry
			sync1_r <= 4'h3;
			sync2_r <= 4'h3;
			sck_d_r <= 1'b1;
			cs_b_d_r <= 1'b1;
		end else begin
			sync1_r <= {commutation_enable_pin, spi_sdi, spi_cs_b, spi_sck};
			sync2_r <= sync1_r;
			sck_d_r <= sync2_r[0];
			cs_b_d_r <= sync2_r[1];
		end
	end

	assign sck_s = sync2_r[0];
	assign cs_b_s = sync2_r[1];
	assign sdi_s = sync2_r[2];
	assign en_pin_s = sync2_r[3];

	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;
	assign sck_rise = sck_s & ~sck_d_r & ~cs_b_s;
	assign sck_fall = ~sck_s & sck_d_r & ~cs_b_s;
	assign cs_fall = ~cs_b_s & cs_b_d_r;
	assign cs_rise = cs_b_s & ~cs_b_d_r;

	// ==========================================================
	// datagram shifter
	logic [39:0] rx_r;
	logic [39:0] tx_r;
	logic [5:0] bit_cnt_r;
	logic [31:0] read_next_r;
	logic write_go;
	logic [6:0] rx_addr;

	assign rx_addr = rx_r[`DCR_ADDR_MSB:`DCR_ADDR_LSB];
	// short or long frames are dropped whole
	assign write_go = cs_rise & rx_r[`DCR_WRITE_BIT]
		& (bit_cnt_r == 6'(`DCR_DATAGRAM_BITS));

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rx_r <= 40'h0000000000;
			bit_cnt_r <= 6'h00;
		end else if (cs_fall) begin
			bit_cnt_r <= 6'h00;
		end else if (sck_rise) begin
			rx_r <= {rx_r[38:0], sdi_s};
			if (bit_cnt_r != 6'h3f) begin
				bit_cnt_r <= bit_cnt_r + 6'h01;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tx_r <= 40'h0000000000;
		end else if (cs_fall) begin
			tx_r <= {spi_status, read_next_r};
		end else if (sck_fall) begin
			tx_r <= {tx_r[38:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			spi_sdo <= 1'b0;
			spi_sdo_oe <= 1'b0;
		end else begin
			spi_sdo <= tx_r[39];
			spi_sdo_oe <= ~cs_b_s;
		end
	end

	// ==========================================================
	// configuration registers
	logic [23:0] commutation_control_r;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			chopper_config <= `DCR_RST_CHOPPER_CONFIG; // RULE9
		end else if (write_go && rx_addr == `DCR_ADDR_CHOPPER_CONFIG) begin
			chopper_config <= rx_r[31:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			current_control_config <= 25'h0000000;
		end else if (write_go
			&& rx_addr == `DCR_ADDR_CURRENT_CONTROL_CONFIG) begin
			current_control_config <= rx_r[24:0]; // RULE12
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			commutation_control_r <= 24'h000000;
		end else if (write_go && rx_addr == `DCR_ADDR_COMMUTATION_CONTROL) begin
			commutation_control_r <= rx_r[23:0]; // RULE12
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			voltage_pwm_config <= `DCR_RST_VOLTAGE_PWM_CONFIG; // RULE10
		end else if (write_go && rx_addr == `DCR_ADDR_VOLTAGE_PWM_CONFIG) begin
			voltage_pwm_config <= rx_r[21:0]; // RULE12
		end
	end

	// ==========================================================
	// read side; write-only and unmapped addresses answer zero
	logic [31:0] read_mux;

	always_comb begin
		case (rx_addr)
			`DCR_ADDR_CHOPPER_CONFIG: read_mux = chopper_config; // RULE9
			`DCR_ADDR_DRIVER_STATUS: read_mux = driver_status_in; // RULE11
			`DCR_ADDR_PWM_AMPLITUDE_RESULT: begin
				read_mux = {7'h00, amp_in.scale_auto, 8'h00,
					amp_in.actual_duty_cycle}; // RULE6 RULE7
			end
			`DCR_ADDR_PWM_AUTO_RESULT: begin
				read_mux = {8'h00, auto_in.gradient_auto, 8'h00,
					auto_in.offset_auto}; // RULE8
			end
			default: read_mux = `DCR_RST_ZERO;
		endcase
	end

	// answer is fetched at frame end so the next frame returns it
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			read_next_r <= `DCR_RST_ZERO;
		end else if (cs_rise && bit_cnt_r == 6'(`DCR_DATAGRAM_BITS)) begin
			read_next_r <= read_mux;
		end
	end

	// ==========================================================
	// commutation on-time supervision
	logic [9:0] time_limit;
	logic [7:0] stall_limit;
	logic [11:0] on_cnt_r;
	logic mode_on;
	logic stall_on;

	assign time_limit =
		commutation_control_r[`DCR_TIME_LIMIT_MSB:`DCR_TIME_LIMIT_LSB];
	assign stall_limit =
		commutation_control_r[`DCR_STALL_LIMIT_MSB:`DCR_STALL_LIMIT_LSB];
	assign mode_on = en_pin_s | (min_commutation_velocity != 23'h000000); // RULE4
	assign stall_on = (stall_limit != 8'h00) // RULE3
		& (mode_on | (high_velocity_fullstep_en
		& above_high_velocity_threshold)); // RULE5

	// saturating so a stuck on-phase never wraps back under the limit
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			on_cnt_r <= 12'h000;
		end else if (!pwm_on) begin
			on_cnt_r <= 12'h000;
		end else if (on_cnt_r != 12'hfff) begin
			on_cnt_r <= on_cnt_r + 12'h001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			limits <= '0;
			auto_commutation_active <= 1'b0;
			stall_detect_active <= 1'b0;
			commutation_cut <= 1'b0;
			step_loss <= 1'b0;
		end else begin
			limits <= {stall_limit, time_limit};
			auto_commutation_active <= mode_on;
			stall_detect_active <= stall_on;
			commutation_cut <= mode_on & pwm_on
				& (on_cnt_r >= 12'(time_limit) * 12'(`DCR_TIME_LIMIT_UNIT_CYC)); // RULE1
			step_loss <= stall_on & pwm_on
				& (on_cnt_r >= 12'(stall_limit) * 12'(`DCR_STALL_LIMIT_UNIT_CYC)); // RULE2
		end
	end
endmodule

// >>> dcr_regs_asserts.sv
// concurrent checks on the driver configuration/status register bank
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ns
module dcr_regs_asserts (
	input wire logic clk_sys, // device clock
	input wire logic rst_b, // sync reset, active low
	input wire logic spi_cs_b, // chip select pin
	input wire logic spi_sdo_oe, // sdo enable
	input wire logic [22:0] min_commutation_velocity, // velocity floor
	input wire logic pwm_on, // pwm on-phase
	input wire logic [31:0] chopper_config, // rw register
	input wire logic [21:0] voltage_pwm_config, // wo register
	input wire dcr_pkg::dcr_limits_t limits, // commutation limits
	input wire logic auto_commutation_active, // mode on
	input wire logic stall_detect_active, // step-loss armed
	input wire logic commutation_cut, // on-time cut
	input wire logic step_loss // step loss seen
);
	import dcr_pkg::*;
	// ==========================================================
	// on-time reference counter
	logic [11:0] on_r;
	logic [11:0] tl_w;
	logic [11:0] sl_w;
	assign tl_w = {2'h0, limits.commutation_time_limit};
	assign sl_w = {limits.commutation_stall_limit, 4'h0};
	always_ff @(posedge clk_sys) begin
		if (!rst_b || !pwm_on)
			on_r <= 12'h000;
		else if (on_r != 12'hfff)
			on_r <= on_r + 12'h001;
	end
	// ==========================================================
	// properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	reset_value_a: assert property (
		$rose(rst_b) |-> chopper_config == 32'h10410150 &&
		voltage_pwm_config == 22'h0c001e)
		else $error("register not at reset value");
	cfg_hold_a: assert property (
		spi_cs_b [*8] |-> $stable(chopper_config) &&
		$stable(voltage_pwm_config))
		else $error("register changed without a frame");
	oe_idle_a: assert property (spi_cs_b [*4] |-> !spi_sdo_oe)
		else $error("sdo driven while deselected");
	oe_drive_a: assert property (!spi_cs_b [*4] |-> spi_sdo_oe)
		else $error("sdo not driven while selected");
	auto_mode_a: assert property (
		min_commutation_velocity != 23'h0 |=> auto_commutation_active)
		else $error("commutation mode not entered");
	stall_off_a: assert property (
		limits.commutation_stall_limit == 8'h00 ##1
		limits.commutation_stall_limit == 8'h00 |-> !stall_detect_active)
		else $error("step-loss check armed at zero limit");
	cut_early_a: assert property (
		commutation_cut |-> $past(pwm_on) && on_r >= tl_w)
		else $error("on-time cut too early");
	cut_late_a: assert property (
		auto_commutation_active && pwm_on && on_r > tl_w + 12'h003
		|-> commutation_cut)
		else $error("on-time cut missing");
	loss_early_a: assert property (
		step_loss |-> $past(pwm_on) && on_r >= sl_w)
		else $error("step loss too early");
	loss_late_a: assert property (
		stall_detect_active && pwm_on && on_r > sl_w + 12'h003
		|-> step_loss)
		else $error("step loss missing");
endmodule
bind dcr_driver_config_status_regs dcr_regs_asserts u_chk (.clk_sys,
	.rst_b, .spi_cs_b, .spi_sdo_oe, .min_commutation_velocity, .pwm_on,
	.chopper_config, .voltage_pwm_config, .limits,
	.auto_commutation_active, .stall_detect_active, .commutation_cut,
	.step_loss);

// >>> dcr_host_model.sv
// host controller model: 40-bit mode-3 frames, msb first
// assumes the bench paces it from the device clock falling edge
`timescale 1ns/1ns
module dcr_host_model (
	input wire logic clk_sys, // pacing clock
	output logic spi_sck, // idles high
	output logic spi_cs_b, // active low
	output logic spi_sdi, // host data
	input wire logic spi_sdo // device data
);
	initial begin
		spi_sck = 1'b1;
		spi_cs_b = 1'b1;
		spi_sdi = 1'b0;
	end
	// five clocks per sck phase keeps above the three-clock minimum
	task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
		rx = '0;
		@(negedge clk_sys);
		spi_cs_b = 1'b0;
		repeat (5) @(negedge clk_sys);
		// device shows the msb from select and advances on each sck fall,
		// so each bit is taken just before the fall that replaces it
		for (int i = 39; i >= 0; i--) begin
			rx[i] = spi_sdo;
			spi_sck = 1'b0;
			spi_sdi = tx[i];
			repeat (5) @(negedge clk_sys);
			spi_sck = 1'b1;
			repeat (5) @(negedge clk_sys);
		end
		spi_cs_b = 1'b1;
		// released line must not keep looking valid
		spi_sdi = ~spi_sdi;
		repeat (5) @(negedge clk_sys);
	endtask
endmodule

// >>> dcr_tb.sv
// self-checking bench for the register bank over its serial port
// assumes dcr_host_model drives the serial pins
`timescale 1ns/1ns
module testbench;
	import dcr_pkg::*;
	logic clk_sys, rst_b = 0, spi_sck, spi_cs_b, spi_sdi, spi_sdo;
	logic spi_sdo_oe, commutation_enable_pin = 0, pwm_on = 0;
	logic [7:0] spi_status = 8'h5a;
	logic [22:0] min_commutation_velocity = '0;
	logic high_velocity_fullstep_en = 0, above_high_velocity_threshold = 0;
	logic [31:0] driver_status_in = 32'ha5c35a3c, chopper_config;
	dcr_amp_t amp_in = '{9'h101, 8'hff};
	dcr_auto_t auto_in = '{8'h3c, 8'h96};
	logic [24:0] current_control_config;
	logic [21:0] voltage_pwm_config;
	dcr_limits_t limits;
	logic auto_commutation_active, stall_detect_active;
	logic commutation_cut, step_loss;
	int n_errors = 0, checks = 0;
	dcr_driver_config_status_regs uut (.clk_sys, .rst_b, .spi_sck,
		.spi_cs_b, .spi_sdi, .spi_sdo, .spi_sdo_oe, .spi_status,
		.commutation_enable_pin, .min_commutation_velocity,
		.high_velocity_fullstep_en, .above_high_velocity_threshold,
		.pwm_on, .driver_status_in, .amp_in, .auto_in, .chopper_config,
		.current_control_config, .voltage_pwm_config, .limits,
		.auto_commutation_active, .stall_detect_active,
		.commutation_cut, .step_loss);
	// an undriven sdo reads as the inverse, so a missing enable shows up
	dcr_host_model host (.clk_sys, .spi_sck, .spi_cs_b, .spi_sdi,
		.spi_sdo(spi_sdo_oe ? spi_sdo : ~spi_sdo));
	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] seen, exp, input string nm);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		logic [39:0] rx;
		host.xfer({1'b1, a, d}, rx);
	endtask
	// read answer arrives in the following frame
	task automatic rd(input logic [6:0] a, input logic [31:0] exp);
		logic [39:0] rx;
		host.xfer({1'b0, a, 32'h0}, rx);
		host.xfer({1'b0, 7'h6c, 32'h0}, rx);
		chk({24'h0, rx[39:32]}, 32'h5a, "status byte");
		chk(rx[31:0], exp, "read data");
	endtask
	task automatic close_out;
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// ==========================================================
	// clock, watchdog, tests
	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		n_errors++;
		close_out;
	end
	initial begin
		tick(4);
		rst_b = 1;
		tick(3);
		chk(chopper_config, 32'h10410150, "chopper rst");
		chk({10'h0, voltage_pwm_config}, 32'hc40c001e & 32'h3fffff,
			"pwm cfg rst");
		rd(7'h6c, 32'h10410150);
		wr(7'h6c, 32'hdeadbeef);
		wr(7'h7f, 32'h0);
		rd(7'h6c, 32'hdeadbeef);
		wr(7'h70, 32'hffffffff);
		wr(7'h6d, 32'h01abcdef);
		chk({10'h0, voltage_pwm_config}, 32'h3fffff, "pwm hold");
		chk({7'h0, current_control_config}, 32'h1abcdef, "cc");
		rd(7'h70, 32'h0);
		rd(7'h7f, 32'h0);
		rd(7'h6f, 32'ha5c35a3c);
		rd(7'h71, {7'h0, 9'h101, 8'h0, 8'hff});
		rd(7'h72, {8'h0, 8'h3c, 8'h0, 8'h96});
		wr(7'h6e, {8'h0, 8'h05, 6'h0, 10'h020});
		chk({14'h0, limits}, {14'h0, 8'h05, 10'h020}, "limits");
		chk({31'h0, auto_commutation_active}, 32'h0, "mode off");
		min_commutation_velocity = 23'h000100;
		tick(3);
		chk({31'h0, auto_commutation_active}, 32'h1, "mode vmin");
		min_commutation_velocity = '0;
		commutation_enable_pin = 1;
		tick(5);
		chk({31'h0, auto_commutation_active}, 32'h1, "mode pin");
		pwm_on = 1;
		tick(20);
		chk({31'h0, commutation_cut}, 32'h0, "cut early");
		tick(20);
		chk({31'h0, commutation_cut}, 32'h1, "cut");
		tick(30);
		chk({31'h0, step_loss}, 32'h0, "loss early");
		tick(20);
		chk({31'h0, step_loss}, 32'h1, "loss");
		pwm_on = 0;
		commutation_enable_pin = 0;
		tick(5);
		chk({31'h0, commutation_cut}, 32'h0, "cut off");
		high_velocity_fullstep_en = 1;
		above_high_velocity_threshold = 1;
		tick(3);
		chk({31'h0, stall_detect_active}, 32'h1, "stall hv");
		wr(7'h6e, {8'h0, 8'h00, 6'h0, 10'h020});
		chk({31'h0, stall_detect_active}, 32'h0, "stall off");
		close_out;
	end
endmodule
